// File: hdl/adcctl_core.sv
`timescale 1ns/100ps
// Function
// - One route code selects supply monitor path
// - Over-range result saturates at positive or negative full scale
// - Temperature route forces unity gain
// - Power-down release resets, then loads calibration
// - Writes land on master clock
// - Modulator stays off until start command
// - Listed writes reset filter, hide ready
// - Settle starts at select high; ready falls
// - Pointer and read accesses leave filter alone
// - Standby stops conversions
// - Eight 24-bit offsets, one per gain
// - Calibration shorts input, stores per gain
// - Calibrate bit runs calibration in continuous mode with standby clear, self-clears
// - Mode pattern 10 selects continuous
// - Command bit 7 low means read
// - Conversions restart after calibration
module adcctl_core
    import adcctl_pkg::*;
#(
    parameter logic [CNT_W-1:0]       INIT_CYCLES_P = CNT_W'(INIT_CYCLES),
    parameter logic [7:0][CNT_W-1:0] CONV_CYCLES = {
        28'd25000, 28'd100000, 28'd1000000, 28'd2000000,
        28'd5000000, 28'd10000000, 28'd20000000, 28'd40000000},
    parameter logic [7:0][CNT_W-1:0] SETTLE_CYCLES = {
        28'd100000, 28'd400000, 28'd4000000, 28'd8000000,
        28'd20000000, 28'd40000000, 28'd80000000, 28'd160000000}
)(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     serial_clk,
    input  wire logic                     power_down_n,
    input  wire logic                     chip_select_n,
    input  wire logic                     serial_cmd_in,
    input  wire logic signed [24:0]       conv_raw,
    output      logic                     serial_out_ready_n,
    output      logic [23:0]              conv_word,
    output      logic [7:0]               input_route,
    output      adcctl_pkg::adcctl_status_type status
);
    import adcctl_pkg::*;
    // Link side state
    typedef struct packed {
        logic        rst_s1;   // Reset synchroniser, first stage
        logic        rst_s2;   // Reset synchroniser, second stage
        logic [3:0]  bits;     // Bit count in the frame
        logic [14:0] sh;       // Shift register
        logic [15:0] word;     // Last complete frame
        logic        tgl;      // Toggles per complete frame
    } adcctl_link_type;
    // Master clock side state
    typedef struct packed {
        logic              pdn_s1, pdn_s2, pdn_prev;
        logic              cs_s1, cs_s2, cs_prev;
        logic              tg_s1, tg_s2, tg_seen;
        logic              link_rst;
        adcctl_state_type  st;
        logic [CNT_W-1:0]  cnt;
        logic [2:0]        per;
        adcctl_cfg_type    cfg;
        logic [7:0][23:0]  off;
        logic [23:0]       word;
        logic              rdy_n;
        adcctl_status_type stat;
    } adcctl_sys_type;
    adcctl_link_type  l_q;       // Link registers
    adcctl_link_type  l_d;       // Link next value
    adcctl_sys_type   s_q;       // Core registers
    adcctl_sys_type   s_d;       // Core next value
    adcctl_frame_type frame;     // Frame held on the link side
    logic             commit;    // Write taken this cycle
    logic             filt_wr;   // Write that resets the filter
    logic [CNT_W-1:0] conv_per;  // Conversion period of this rate
    logic [CNT_W-1:0] settle;    // Settle delay of this rate
    logic signed [25:0] diff;    // Raw result less offset
    // Saturate to the 24-bit output span
    function automatic logic [23:0] sat24(input logic signed [25:0] v);
        return (v > 26'sd8388607) ? CODE_POS_FS : ((v < -26'sd8388608) ? CODE_NEG_FS : v[23:0]);
    endfunction
    // Link shift logic on the serial clock; select high clears the count
    always_comb
    begin
        l_d        = l_q;
        l_d.rst_s1 = s_q.link_rst;
        l_d.rst_s2 = l_q.rst_s1;
        l_d.sh     = chip_select_n ? l_q.sh : {l_q.sh[13:0], serial_cmd_in};
        l_d.bits   = chip_select_n ? 4'h0 : l_q.bits + 4'h1;
        // Sixteenth bit inside the frame closes the pair
        if (!chip_select_n && l_q.bits == 4'hF)
        begin
            l_d.word = {l_q.sh, serial_cmd_in};
            l_d.tgl  = ~l_q.tgl;
        end
        // Held in reset while the core is; toggle and word start known
        if (l_q.rst_s2)
        begin
            l_d.bits = '0;
            l_d.sh   = '0;
            l_d.word = '0;
            l_d.tgl  = 1'b0;
        end
    end
    always_ff @(posedge serial_clk)
    begin
        l_q <= l_d;
    end
    // Frame is stable once its toggle is synchronised
    assign frame    = adcctl_frame_type'(l_q.word);
    assign conv_per = CONV_CYCLES[s_q.cfg.rate[2:0]];
    assign settle   = SETTLE_CYCLES[s_q.cfg.rate[2:0]];
    assign diff     = 26'(conv_raw) - 26'(signed'(s_q.off[s_q.cfg.gain[2:0]]));
    // Write taken at select rising edge, master clock
    assign commit = s_q.cs_s2 && !s_q.cs_prev && (s_q.tg_s2 != s_q.tg_seen)
                    && frame.cmd[WRITE_BIT] && s_q.st != ST_INIT;
    // Writes that disturb the filter
    assign filt_wr = commit && (frame.cmd inside {CMD_RATE, CMD_ROUTE, CMD_GAIN,
                     CMD_OUTCTL, CMD_DELAY, CMD_OFF_HI, CMD_OFF_MID, CMD_OFF_LO});
    // Core control
    always_comb
    begin
        s_d          = s_q;
        s_d.pdn_s1   = power_down_n;
        s_d.pdn_s2   = s_q.pdn_s1;
        s_d.pdn_prev = s_q.pdn_s2;
        s_d.cs_s1    = chip_select_n;
        s_d.cs_s2    = s_q.cs_s1;
        s_d.cs_prev  = s_q.cs_s2;
        s_d.tg_s1    = l_q.tgl;
        s_d.tg_s2    = s_q.tg_s1;
        s_d.link_rst = rst || !s_q.pdn_s2;
        if (s_q.cs_s2 && !s_q.cs_prev) // Every closed frame is used up, reads too
            s_d.tg_seen = s_q.tg_s2;
        // Counters and conversion sequence
        unique case (s_q.st)
            ST_INIT:
                if (s_q.cnt == '0) // Calibration load done
                    s_d.st = ST_IDLE;
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            ST_IDLE:
                s_d.rdy_n = 1'b1;
            ST_CONV:
            begin
                s_d.cnt = s_q.cnt - 1'b1;
                // Word done, ready falls
                if (s_q.cnt == '0)
                begin
                    s_d.word  = sat24(diff);
                    s_d.rdy_n = 1'b0;
                    s_d.cnt   = conv_per;
                end
                // Ready rises mid period
                else if (s_q.cnt == (conv_per >> 1))
                    s_d.rdy_n = 1'b1;
            end
            ST_SETTLE:
            begin
                s_d.rdy_n = 1'b1;
                // Delay counts only while select stays high
                if (!s_q.cs_s2)
                    s_d.cnt = settle;
                else if (s_q.cnt == '0)
                begin
                    s_d.st    = ST_CONV;
                    s_d.word  = sat24(diff);
                    s_d.rdy_n = 1'b0;
                    s_d.cnt   = conv_per;
                end
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            ST_CAL:
            begin
                s_d.rdy_n = 1'b1;
                s_d.cnt   = s_q.cnt - 1'b1;
                if (s_q.cnt == '0)
                begin
                    s_d.cnt = conv_per;
                    s_d.per = s_q.per - 3'h1;
                    // Last period stores offset for this gain
                    if (s_q.per == 3'h1)
                    begin
                        s_d.off[s_q.cfg.gain[2:0]] = sat24(26'(conv_raw));
                        s_d.cfg.conv[CAL_BIT]      = 1'b0;
                        s_d.rdy_n                  = 1'b0;
                        s_d.st                     = ST_CONV;
                    end
                end
            end
            default:
                s_d.st = ST_INIT;
        endcase
        // Register writes, after hardware clears so a set wins
        if (commit)
        begin
            unique case (frame.cmd)
                CMD_CONV:    s_d.cfg.conv    = frame.data;
                CMD_RATE:    s_d.cfg.rate    = frame.data;
                CMD_ROUTE:   s_d.cfg.route   = frame.data;
                CMD_PTR:     s_d.cfg.ptr     = frame.data;
                CMD_GAIN:    s_d.cfg.gain    = frame.data;
                CMD_OUTCTL:  s_d.cfg.outctl  = frame.data;
                CMD_STANDBY: s_d.cfg.standby = frame.data;
                CMD_DELAY:   s_d.cfg.delay   = frame.data;
                CMD_OFF_HI:  s_d.off[s_q.cfg.ptr[2:0]][23:16] = frame.data;
                CMD_OFF_MID: s_d.off[s_q.cfg.ptr[2:0]][15:8]  = frame.data;
                CMD_OFF_LO:  s_d.off[s_q.cfg.ptr[2:0]][7:0]   = frame.data;
                default:     s_d.cfg = s_d.cfg;
            endcase
            // Standby or other mode stops conversions
            if (s_d.cfg.standby[0] || s_d.cfg.conv[1:0] != CONV_MODE_CONT)
            begin
                s_d.st    = ST_IDLE;
                s_d.rdy_n = 1'b1;
            end
            // Calibration request pauses conversions
            else if (frame.cmd == CMD_CONV && frame.data[CAL_BIT])
            begin
                s_d.st  = ST_CAL;
                s_d.per = 3'(CAL_PERIODS);
                s_d.cnt = conv_per;
            end
            // Filter reset during running conversions
            else if (filt_wr && (s_q.st == ST_CONV || s_q.st == ST_SETTLE))
            begin
                s_d.st    = ST_SETTLE;
                s_d.cnt   = SETTLE_CYCLES[s_d.cfg.rate[2:0]]; // Rate after this write
                s_d.rdy_n = 1'b1;
            end
            // Start command leaves low power
            else if (s_q.st == ST_IDLE)
            begin
                s_d.st  = ST_CONV;
                s_d.cnt = conv_per;
            end
        end
        // Reset and power-down hold, released into init
        if (rst || !s_q.pdn_s2)
        begin
            s_d.st      = ST_INIT;
            s_d.cnt     = INIT_CYCLES_P;
            s_d.per     = '0;
            s_d.cfg     = CFG_RST;
            s_d.off     = '0;
            s_d.word    = '0;
            s_d.rdy_n   = 1'b1;
            s_d.tg_seen = s_q.tg_s2;
        end
        // Synchronisers start at the idle levels of their pins
        if (rst)
        begin
            {s_d.pdn_s1, s_d.pdn_s2, s_d.pdn_prev} = 3'h0;
            {s_d.cs_s1, s_d.cs_s2, s_d.cs_prev}    = 3'h7;
            {s_d.tg_s1, s_d.tg_s2, s_d.tg_seen}    = 3'h0;
        end
        // Front end status from the next state
        s_d.stat.init_busy         = s_d.st == ST_INIT;
        s_d.stat.modulator_on      = s_d.st inside {ST_CONV, ST_SETTLE, ST_CAL};
        s_d.stat.input_shorted     = s_d.st == ST_CAL;
        s_d.stat.supply_monitor_on = s_d.cfg.route == ROUTE_SUPPLY;
        s_d.stat.gain_applied      = (s_d.cfg.route == ROUTE_TEMP) ? 3'h0
                                     : s_d.cfg.gain[2:0];
    end
    always_ff @(posedge sys_clk)
    begin
        s_q <= s_d;
    end
    // Outputs straight from registers
    assign serial_out_ready_n = s_q.rdy_n;
    assign conv_word          = s_q.word;
    assign input_route        = s_q.cfg.route;
    assign status             = s_q.stat;
    // Checks on the master clock
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_cal_end;
        s_q.st == ST_CAL ##1 s_q.st == ST_CONV;
    endsequence
    sequence s_filt_in_run;
        filt_wr && s_q.st == ST_CONV && !s_d.cfg.standby[0]
        && s_d.cfg.conv[1:0] == CONV_MODE_CONT && !s_d.cfg.conv[CAL_BIT];
    endsequence

    property p_temp_gain;
        s_q.cfg.route == ROUTE_TEMP |-> status.gain_applied == 3'h0;
    endproperty
    a_temp_gain: assert property (p_temp_gain) else $error("gain not forced");
    property p_saturate;
        s_q.st == ST_CONV && s_q.cnt == '0 && diff > 26'sd8388607
        |=> conv_word == CODE_POS_FS;
    endproperty
    a_saturate: assert property (p_saturate) else $error("no saturation");
    property p_pdn_init;
        $rose(s_q.pdn_s2) |=> s_q.st == ST_INIT && status.init_busy;
    endproperty
    a_pdn_init: assert property (p_pdn_init) else $error("no init on release");
    property p_rate_write;
        commit && frame.cmd == CMD_RATE |=> s_q.cfg.rate == $past(frame.data);
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("rate not written");
    property p_idle_off;
        s_q.st == ST_IDLE |-> !status.modulator_on && serial_out_ready_n;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("modulator on in idle");
    property p_filt_settle;
        s_filt_in_run |=> s_q.st == ST_SETTLE && serial_out_ready_n;
    endproperty
    a_filt_settle: assert property (p_filt_settle) else $error("no filter reset");
    property p_ptr_quiet;
        commit && frame.cmd == CMD_PTR && s_q.st == ST_CONV |=> s_q.st == ST_CONV;
    endproperty
    a_ptr_quiet: assert property (p_ptr_quiet) else $error("pointer disturbed");
    property p_standby;
        commit && frame.cmd == CMD_STANDBY && frame.data[0] |=> s_q.st == ST_IDLE;
    endproperty
    a_standby: assert property (p_standby) else $error("standby ignored");
    property p_cal_done;
        s_cal_end |-> !s_q.cfg.conv[CAL_BIT] && !serial_out_ready_n;
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("cal end wrong");
    property p_settle_hold;
        s_q.st == ST_SETTLE && !s_q.cs_s2 |=> s_q.cnt == $past(settle);
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle ran early");
endmodule

// File: hdl/adcctl_pkg.sv
package adcctl_pkg;
    // Command codes, write flag in bit 7
    localparam logic [7:0] CMD_CONV    = 8'h84;
    localparam logic [7:0] CMD_RATE    = 8'h85;
    localparam logic [7:0] CMD_ROUTE   = 8'h87;
    localparam logic [7:0] CMD_PTR     = 8'h88;
    localparam logic [7:0] CMD_GAIN    = 8'h97;
    localparam logic [7:0] CMD_OUTCTL  = 8'h81;
    localparam logic [7:0] CMD_STANDBY = 8'h82;
    localparam logic [7:0] CMD_DELAY   = 8'h83;
    localparam logic [7:0] CMD_OFF_HI  = 8'hBD;
    localparam logic [7:0] CMD_OFF_MID = 8'hBE;
    localparam logic [7:0] CMD_OFF_LO  = 8'hBF;
    // Field positions
    localparam int         WRITE_BIT     = 7;
    localparam int         CAL_BIT       = 2;
    localparam logic [1:0] CONV_MODE_CONT = 2'h2;
    // Route codes for the monitors
    localparam logic [7:0] ROUTE_SUPPLY  = 8'h08;
    localparam logic [7:0] ROUTE_TEMP    = 8'h09;
    // Full scale limits of the output word
    localparam logic [23:0] CODE_POS_FS  = 24'h7F_FFFF;
    localparam logic [23:0] CODE_NEG_FS  = 24'h80_0000;
    // Timing
    localparam int SYS_CLK_NS   = 10;
    localparam int INIT_TIME_NS = 12_600_000;
    localparam int INIT_CYCLES  = INIT_TIME_NS / SYS_CLK_NS;
    localparam int CAL_PERIODS  = 5;
    localparam int CNT_W        = 28;
    // States, Gray along init, idle, run, settle, calibrate
    typedef enum logic [2:0] {
        ST_INIT   = 3'h0,
        ST_IDLE   = 3'h1,
        ST_CONV   = 3'h3,
        ST_SETTLE = 3'h2,
        ST_CAL    = 3'h6
    } adcctl_state_type;
    // One framed command and data pair
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } adcctl_frame_type;
    // Software visible configuration
    typedef struct packed {
        logic [7:0] conv;
        logic [7:0] rate;
        logic [7:0] route;
        logic [7:0] ptr;
        logic [7:0] gain;
        logic [7:0] outctl;
        logic [7:0] standby;
        logic [7:0] delay;
    } adcctl_cfg_type;
    localparam adcctl_cfg_type CFG_RST = '0;
    // Status toward the analogue front end
    typedef struct packed {
        logic       init_busy;
        logic       modulator_on;
        logic       input_shorted;
        logic       supply_monitor_on;
        logic [2:0] gain_applied;
    } adcctl_status_type;
endpackage

// File: tb/adcctl_host_model.sv
`timescale 1ns/100ps
// Host controller driving the serial control port
module adcctl_host_model
    import adcctl_pkg::*;
(
    input  wire logic sys_clk,
    output      logic serial_clk,
    output      logic chip_select_n,
    output      logic serial_cmd_in
);
    import adcctl_pkg::*;
    // Idle: select high, link clock parked low
    initial
    begin
        serial_clk    = 1'b0;
        chip_select_n = 1'b1;
        serial_cmd_in = 1'b0;
    end
    // Clock burst with select high, clears the link bit counter
    task automatic flush();
        repeat (4)
        begin
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
    endtask
    // One framed command/data pair, MSB first, 12 ns link period
    task automatic send(input adcctl_frame_type fr);
        @(posedge sys_clk);
        #1 chip_select_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            #3 serial_cmd_in = fr[i];
            #3 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
        @(posedge sys_clk);
        #1 chip_select_n = 1'b1;
        // Released data line must not show the stale last bit
        serial_cmd_in = ~serial_cmd_in;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

// File: tb/test_adcctl_startup_config_calibration_control.sv
`timescale 1ns/100ps
module test_adcctl_startup_config_calibration_control;
    import adcctl_pkg::*;
    // One table row: frame and the outputs it should give
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] route;
        logic [2:0] gain;
        logic       sup;
    } adcctl_row_type;
    logic               sys_clk;
    logic               rst;
    logic               serial_clk;
    logic               power_down_n;
    logic               chip_select_n;
    logic               serial_cmd_in;
    logic signed [24:0] conv_raw;
    logic               serial_out_ready_n;
    logic [23:0]        conv_word;
    logic [7:0]         input_route;
    adcctl_status_type  status;
    int                 errors;
    int                 tests_run;
    int                 n;
    adcctl_row_type     rows [7];
    // Short init and conversion counts, settle table 60 + 10 * rate
    adcctl_core #(
        .INIT_CYCLES_P (28'd20),
        .CONV_CYCLES   ({8{28'd40}}),
        .SETTLE_CYCLES ({28'd130, 28'd120, 28'd110, 28'd100,
                         28'd90, 28'd80, 28'd70, 28'd60})
    ) DUT (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .serial_clk         (serial_clk),
        .power_down_n       (power_down_n),
        .chip_select_n      (chip_select_n),
        .serial_cmd_in      (serial_cmd_in),
        .conv_raw           (conv_raw),
        .serial_out_ready_n (serial_out_ready_n),
        .conv_word          (conv_word),
        .input_route        (input_route),
        .status             (status)
    );
    // Far side host
    adcctl_host_model host (
        .sys_clk       (sys_clk),
        .serial_clk    (serial_clk),
        .chip_select_n (chip_select_n),
        .serial_cmd_in (serial_cmd_in)
    );
    // 100 MHz master clock
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Cycles until the next falling edge of ready, lim if none
    task automatic wait_fall(input int lim, output int cnt);
        logic prev;
        prev = serial_out_ready_n;
        for (cnt = 0; cnt < lim; cnt++)
        begin
            @(posedge sys_clk);
            #1;
            if (prev === 1'b1 && serial_out_ready_n === 1'b0)
                break;
            prev = serial_out_ready_n;
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #200_000;
        errors++;
        final_report();
    end
    // Main sequence
    initial
    begin
        errors       = 0;
        tests_run    = 0;
        rst          = 1'b1;
        power_down_n = 1'b0;
        conv_raw     = 25'sd1000;
        rows[0] = {8'h97, 8'h05, 8'h00, 3'd5, 1'b0};
        rows[1] = {8'h87, 8'h09, 8'h09, 3'd0, 1'b0};
        rows[2] = {8'h87, 8'h08, 8'h08, 3'd5, 1'b1};
        rows[3] = {8'h07, 8'h03, 8'h08, 3'd5, 1'b1};
        rows[4] = {8'h85, 8'h03, 8'h08, 3'd5, 1'b1};
        rows[5] = {8'h87, 8'h01, 8'h01, 3'd5, 1'b0};
        rows[6] = {8'h88, 8'h01, 8'h01, 3'd5, 1'b0};
        host.flush();
        repeat (10) @(posedge sys_clk);
        check("ready_n rst", serial_out_ready_n, 1'b1);
        check("route rst", input_route, 8'h00);
        #1 rst = 1'b0;
        power_down_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("busy init", status.init_busy, 1'b1);
        repeat (22) @(posedge sys_clk);
        #1 check("busy done", status.init_busy, 1'b0);
        host.flush(); // Link leaves reset before the first frame
        // Configuration table
        foreach (rows[i])
        begin
            host.send({rows[i].cmd, rows[i].data});
            check("route", input_route, rows[i].route);
            check("gain", status.gain_applied, rows[i].gain);
            check("supply", status.supply_monitor_on, rows[i].sup);
        end
        // Low power until start
        check("mod off", status.modulator_on, 1'b0);
        wait_fall(100, n);
        check("no ready", n, 100);
        host.send({CMD_CONV, 8'h02});
        check("mod on", status.modulator_on, 1'b1);
        wait_fall(60, n);
        check("word", conv_word, 24'h00_03E8);
        // Saturation at both ends
        conv_raw = 25'h0FF_FFFF;
        wait_fall(60, n);
        wait_fall(60, n);
        check("pos fs", conv_word, CODE_POS_FS);
        conv_raw = 25'h100_0000;
        wait_fall(60, n);
        check("neg fs", conv_word, CODE_NEG_FS);
        conv_raw = 25'sd1000;
        // Settle delay from each table entry
        for (int r = 0; r < 8; r++)
        begin
            wait_fall(60, n);
            host.send({CMD_RATE, 8'(r)});
            wait_fall(300, n);
            check("settle", n inside {[60 + 10 * r - 10 : 60 + 10 * r + 2]}, 1'b1);
        end
        // Pointer write does not restart the filter
        wait_fall(60, n);
        host.send({CMD_PTR, 8'h01});
        wait_fall(60, n);
        check("no settle", n < 45, 1'b1);
        // Offset calibration at gain 5
        host.send({CMD_RATE, 8'h00}); // slowest rate of the default table
        conv_raw = 25'sd500;
        host.send({CMD_CONV, 8'h06});
        check("shorted", status.input_shorted, 1'b1);
        wait_fall(260, n);
        check("cal done", n < 260, 1'b1);
        check("unshorted", status.input_shorted, 1'b0);
        conv_raw = 25'sd700;
        wait_fall(60, n);
        wait_fall(60, n);
        check("restart", n < 60, 1'b1);
        check("offset", conv_word, 24'h00_00C8);
        host.send({CMD_GAIN, 8'h02});
        host.send({CMD_PTR, 8'h02}); // select low again restarts the delay
        wait_fall(200, n);
        check("resettle", n inside {[50 : 60]}, 1'b1);
        check("other gain", conv_word, 24'h00_02BC);
        // Standby stops conversion
        host.send({CMD_STANDBY, 8'h01});
        check("standby", status.modulator_on, 1'b0);
        wait_fall(100, n);
        check("stopped", n, 100);
        final_report();
    end
endmodule
